// ===== rtl/twm_master.sv
// two-wire serial master with avalon-mm register block
`timescale 1ns/10ps
// Overview of operation
// - size field 00..11 selects zero to three internal address bytes.
// - direction bit zero writes, one reads.
// - programmed slave address goes out at every transfer start.
// - internal address bytes come from the 24-bit register, msb byte first.
// - clock low lasts low divider times two-power exponent plus three cycles.
// - clock high lasts high divider times two-power exponent plus three cycles.
// - exponent widens both phases; fields at 7:0, 15:8, 18:16.
// - complete flag cleared at frame start, set after stop, on not_acknowledged, or on enable.
// - rx ready set on received byte, cleared by reading rx holding.
// - tx ready cleared by write, set on shift, not_acknowledged, or enable.
// - not_acknowledged flag set with complete on missing ack to a written byte (read-pass address ack not checked), cleared by status read.
// - one written to enable register sets mask bit.
// - one written to disable register clears mask bit.
// - mask register reads enabled sources at status bit positions.
// - rx holding shows last byte in bits 7:0, upper bits zero.
// - tx holding bits 7:0 writable and readable back.
// - start, seven-bit address, then direction bit.
// - write ends with automatic stop once holding and shifter are empty.
// - read ends with automatic stop on a stop request; master answers that byte with not_acknowledged.
module twm_master
    import twm_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [7:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output twm_pkg::twm_pins_type    pins,
    output logic                     irq
);
    import twm_pkg::*;

    typedef enum {S_IDLE, S_START, S_BIT, S_ACK, S_RSTART, S_STOP, S_DONE} twm_state_type;

    twm_mode_type  mode;
    logic [23:0]   iaddr;
    logic [18:0]   clkwave;
    logic          st_complete, st_rx_ready, st_tx_ready, st_not_acknowledged;
    logic [3:0]    mask;
    logic [7:0]    rx_byte, tx_byte;
    logic          enabled, stop_req, start_req, tx_pending;
    logic          acked;
    twm_state_type state;
    logic [8:0]    shifter;
    logic [3:0]    bitcnt;
    logic [2:0]    phase_seq;
    logic [1:0]    bytes_left;
    logic          addr_phase, second_pass, is_read_phase;
    logic          scl_half;
    logic [18:0]   tick;
    logic [18:0]   next_limit;
    logic          scl_q, sda_q, sda_oe_q;
    logic          tick_done;
    logic [31:0]   status_word;
    logic          hit_wr, hit_rd, byte_end_evt, rx_evt, not_acknowledged_evt, shift_evt, stop_evt;

    assign hit_wr = avs_write && !avs_waitrequest;
    assign hit_rd = avs_read && !avs_waitrequest;
    assign status_word = {23'h0, st_not_acknowledged, 4'h0, STATUS_RESET[3], st_tx_ready, st_rx_ready, st_complete};

    // one wait state per access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && avs_waitrequest) begin
            case (avs_address)
                OFS_MODE:     avs_readdata <= {8'h0, 1'b0, mode.slave_device_address, 3'h0,
                                               mode.read_direction, 2'h0,
                                               mode.internal_addr_size, 8'h0};
                OFS_IADDR:    avs_readdata <= {8'h0, iaddr};
                OFS_CLKWAVE:  avs_readdata <= {13'h0, clkwave};
                OFS_STATUS:   avs_readdata <= status_word;
                OFS_IRQ_MASK: avs_readdata <= {23'h0, mask[3], 5'h0, mask[2:0]};
                OFS_RX_HOLD:  avs_readdata <= {24'h0, rx_byte};
                OFS_TX_HOLD:  avs_readdata <= {24'h0, tx_byte};
                default:      avs_readdata <= 32'h0;
            endcase
        end
    end

    logic swrst;
    assign swrst = hit_wr && avs_address == OFS_CTRL && avs_writedata[CTRL_SWRST_BIT];

    // configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode    <= '0;
            iaddr   <= 24'h0;
            clkwave <= 19'h0;
            tx_byte <= 8'h0;
        end else if (swrst) begin
            mode    <= '0;
            iaddr   <= 24'h0;
            clkwave <= 19'h0;
            tx_byte <= 8'h0;
        end else if (hit_wr) begin
            case (avs_address)
                OFS_MODE: begin
                    mode.internal_addr_size   <= avs_writedata[MODE_SIZE_LSB +: 2];
                    mode.read_direction       <= avs_writedata[MODE_READ_BIT];
                    mode.slave_device_address <= avs_writedata[MODE_DADDR_LSB +: 7];
                end
                OFS_IADDR:   iaddr   <= avs_writedata[23:0];
                OFS_CLKWAVE: clkwave <= avs_writedata[18:0];
                OFS_TX_HOLD: tx_byte <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // interrupt mask set and clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= 4'h0;
        end else if (swrst) begin
            mask <= 4'h0;
        end else if (hit_wr && avs_address == OFS_IRQ_EN) begin
            mask <= mask | {avs_writedata[ST_NOT_ACKNOWLEDGED_BIT], avs_writedata[2:0]};
        end else if (hit_wr && avs_address == OFS_IRQ_DIS) begin
            mask <= mask & ~{avs_writedata[ST_NOT_ACKNOWLEDGED_BIT], avs_writedata[2:0]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(mask & {st_not_acknowledged, st_tx_ready, st_rx_ready, st_complete});
        end
    end

    logic ctl_wr, en_wr;
    assign ctl_wr = hit_wr && avs_address == OFS_CTRL;
    assign en_wr  = ctl_wr && avs_writedata[CTRL_ENABLE_BIT] && !avs_writedata[CTRL_DISABLE_BIT];

    // control requests
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enabled    <= 1'b0;
            start_req  <= 1'b0;
            stop_req   <= 1'b0;
            tx_pending <= 1'b0;
        end else if (swrst) begin
            enabled    <= 1'b0;
            start_req  <= 1'b0;
            stop_req   <= 1'b0;
            tx_pending <= 1'b0;
        end else begin
            if (en_wr) enabled <= 1'b1;
            else if (ctl_wr && avs_writedata[CTRL_DISABLE_BIT]) enabled <= 1'b0;
            if (ctl_wr && avs_writedata[CTRL_START_BIT]) start_req <= 1'b1;
            else if (state == S_START) start_req <= 1'b0;
            if (ctl_wr && avs_writedata[CTRL_STOP_BIT]) stop_req <= 1'b1;
            else if (state == S_STOP) stop_req <= 1'b0;
            if (hit_wr && avs_address == OFS_TX_HOLD) tx_pending <= 1'b1;
            else if (shift_evt || not_acknowledged_evt) tx_pending <= 1'b0;
        end
    end

    // status flags; hardware set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {st_not_acknowledged, st_tx_ready, st_rx_ready, st_complete} <= {STATUS_RESET[ST_NOT_ACKNOWLEDGED_BIT],
                STATUS_RESET[ST_TX_READY_BIT], STATUS_RESET[ST_RX_READY_BIT],
                STATUS_RESET[ST_COMPLETE_BIT]};
        end else if (swrst) begin
            {st_not_acknowledged, st_tx_ready, st_rx_ready, st_complete} <= {STATUS_RESET[ST_NOT_ACKNOWLEDGED_BIT],
                STATUS_RESET[ST_TX_READY_BIT], STATUS_RESET[ST_RX_READY_BIT],
                STATUS_RESET[ST_COMPLETE_BIT]};
        end else begin
            if (stop_evt || not_acknowledged_evt || en_wr) st_complete <= 1'b1;
            else if (state == S_START) st_complete <= 1'b0;
            if (rx_evt) st_rx_ready <= 1'b1;
            else if (hit_rd && avs_address == OFS_RX_HOLD) st_rx_ready <= 1'b0;
            if (shift_evt || not_acknowledged_evt || en_wr) st_tx_ready <= 1'b1;
            else if (hit_wr && avs_address == OFS_TX_HOLD) st_tx_ready <= 1'b0;
            if (not_acknowledged_evt) st_not_acknowledged <= 1'b1;
            else if (hit_rd && avs_address == OFS_STATUS) st_not_acknowledged <= 1'b0;
        end
    end

    // phase length: divider shifted by exponent plus three
    always_comb begin
        next_limit = 19'((scl_half ? 19'(clkwave[CLK_HIGH_LSB +: 8]) : 19'(clkwave[7:0]))
                     << clkwave[CLK_EXP_LSB +: 3]) + 19'(CLK_EXTRA) - 19'h1;
    end
    assign tick_done = tick >= next_limit;

    logic wants_read;
    assign wants_read = mode.read_direction && (mode.internal_addr_size == 2'b00 || second_pass);

    // bit engine: scl_half 0 = low phase, 1 = high phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= S_IDLE;
            tick          <= 19'h0;
            scl_half      <= 1'b1;
            scl_q         <= 1'b1;
            sda_q         <= 1'b1;
            sda_oe_q      <= 1'b0;
            shifter       <= 9'h1FF;
            bitcnt        <= 4'h0;
            bytes_left    <= 2'h0;
            addr_phase    <= 1'b0;
            second_pass   <= 1'b0;
            is_read_phase <= 1'b0;
            rx_byte       <= 8'h0;
            acked         <= 1'b0;
        end else if (swrst) begin
            state    <= S_IDLE;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            sda_oe_q <= 1'b0;
            scl_half <= 1'b1;
            tick     <= 19'h0;
        end else begin
            tick <= tick_done ? 19'h0 : tick + 19'h1;
            case (state)
                S_IDLE: begin
                    scl_q    <= 1'b1;
                    scl_half <= 1'b1;
                    tick     <= 19'h0;
                    second_pass <= 1'b0;
                    if (enabled && (start_req || (!mode.read_direction && tx_pending))) begin
                        state    <= S_START;
                        sda_oe_q <= 1'b1;
                        sda_q    <= 1'b0;
                    end
                end
                S_RSTART: if (tick_done) begin
                    // release the clock with data high, then pull data low as a start
                    if (!scl_half) begin
                        scl_q    <= 1'b1;
                        scl_half <= 1'b1;
                    end else begin
                        sda_oe_q <= 1'b1;
                        sda_q    <= 1'b0;
                        state    <= S_START;
                    end
                end
                S_START: if (tick_done) begin
                    shifter    <= {mode.slave_device_address, wants_read, 1'b1};
                    is_read_phase <= wants_read;
                    bytes_left <= wants_read ? 2'h0 : mode.internal_addr_size;
                    addr_phase <= 1'b1;
                    bitcnt     <= 4'h0;
                    scl_q      <= 1'b0;
                    scl_half   <= 1'b0;
                    state      <= S_BIT;
                end
                S_BIT: begin
                    // first bit changes one cycle after the clock falls, never as it rises
                    if (!scl_half && bitcnt == 4'h0 && tick == 19'h0) begin
                        sda_oe_q <= !(is_read_phase && !addr_phase);
                        sda_q    <= shifter[8];
                    end
                    if (tick_done) begin
                        scl_half <= !scl_half;
                        scl_q    <= !scl_half;
                        if (scl_half) begin
                            if (is_read_phase && !addr_phase)
                                rx_byte <= {rx_byte[6:0], sda_i};
                            bitcnt <= bitcnt + 4'h1;
                            if (bitcnt == 4'h7) begin
                                state    <= S_ACK;
                                // master drives ack on reads unless stop is requested, releases for slave ack
                                sda_oe_q <= is_read_phase && !addr_phase && !stop_req;
                                sda_q    <= 1'b0;
                            end else begin
                                sda_oe_q <= !(is_read_phase && !addr_phase);
                                sda_q    <= shifter[7];
                                shifter  <= {shifter[7:0], 1'b1};
                            end
                        end
                    end
                end
                S_ACK: if (tick_done) begin
                    scl_half <= !scl_half;
                    scl_q    <= !scl_half;
                    if (!scl_half) acked <= !sda_i;
                    if (scl_half) begin
                        bitcnt   <= 4'h0;
                        addr_phase <= 1'b0;
                        if (!is_read_phase && !acked) begin
                            state <= S_STOP;
                        end else if (is_read_phase && !addr_phase && stop_req) begin
                            state <= S_STOP;
                        end else if (bytes_left != 2'h0) begin
                            bytes_left <= bytes_left - 2'h1;
                            // internal address bytes, most significant first
                            shifter <= {iaddr[8 * (32'(bytes_left) - 1) +: 8], 1'b1};
                        end else if (mode.read_direction && !is_read_phase) begin
                            second_pass <= 1'b1;
                            state <= S_RSTART;
                            sda_oe_q <= 1'b0;
                        end else if (is_read_phase) begin
                            state <= S_BIT;
                        end else if (tx_pending) begin
                            shifter <= {tx_byte, 1'b1};
                        end else begin
                            state <= S_STOP;
                        end
                        if (!(!is_read_phase && !acked) && !(is_read_phase && !addr_phase
                            && stop_req) && (bytes_left != 2'h0 || is_read_phase
                            || tx_pending || (mode.read_direction && !is_read_phase)))
                            state <= (bytes_left == 2'h0 && mode.read_direction
                                      && !is_read_phase) ? S_RSTART : S_BIT;
                    end
                end
                S_STOP: begin
                    // data held low while the clock is low, so the rise is no start
                    sda_oe_q <= 1'b1;
                    sda_q    <= 1'b0;
                    if (tick_done) begin
                        scl_q    <= 1'b1;
                        scl_half <= 1'b1;
                        state    <= S_DONE;
                    end
                end
                S_DONE: if (tick_done) begin
                    sda_oe_q <= 1'b0;
                    sda_q    <= 1'b1;
                    state    <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    assign byte_end_evt = state == S_ACK && tick_done && scl_half;
    assign rx_evt    = byte_end_evt && is_read_phase && !addr_phase;
    assign not_acknowledged_evt  = byte_end_evt && !is_read_phase && !acked;
    assign shift_evt = byte_end_evt && !is_read_phase && acked && bytes_left == 2'h0
                       && !addr_phase && tx_pending;
    assign stop_evt  = state == S_DONE && tick_done;

    always_comb begin
        pins.scl_o  = 1'b0;
        pins.scl_oe = !scl_q;
        pins.sda_o  = 1'b0;
        pins.sda_oe = sda_oe_q && !sda_q;
    end

    a_not_acknowledged_sets_complete: assert property (@(posedge clk) disable iff (!rst_n)
        not_acknowledged_evt && !swrst |=> st_not_acknowledged && st_complete && st_tx_ready)
        else $error("not_acknowledged did not set flags");
    a_rx_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
        hit_rd && avs_address == OFS_RX_HOLD && !rx_evt |=> !st_rx_ready)
        else $error("rx ready not cleared");
    a_tx_write_clears: assert property (@(posedge clk) disable iff (!rst_n)
        hit_wr && avs_address == OFS_TX_HOLD && !shift_evt && !not_acknowledged_evt |=> !st_tx_ready)
        else $error("tx ready not cleared");
    a_enable_sets_mask: assert property (@(posedge clk) disable iff (!rst_n)
        hit_wr && avs_address == OFS_IRQ_EN && avs_writedata[0] |=> mask[0])
        else $error("enable did not set mask");
    a_disable_clr_mask: assert property (@(posedge clk) disable iff (!rst_n)
        hit_wr && avs_address == OFS_IRQ_DIS && avs_writedata[0] |=> !mask[0])
        else $error("disable did not clear mask");
    a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 irq == $past(|(mask & {st_not_acknowledged, st_tx_ready, st_rx_ready, st_complete})))
        else $error("irq mismatch");
    a_frame_clears: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_START && !en_wr |=> !st_complete)
        else $error("complete not cleared in frame");
    a_low_phase_len: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(scl_q) && state == S_BIT |-> tick == 19'h0)
        else $error("low phase not restarted");
endmodule : twm_master

// ===== rtl/twm_pkg.sv
// package for the two-wire master register block
package twm_pkg;
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_MODE      = 8'h04;
    localparam logic [7:0] OFS_IADDR     = 8'h0C;
    localparam logic [7:0] OFS_CLKWAVE   = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h24;
    localparam logic [7:0] OFS_IRQ_DIS   = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h2C;
    localparam logic [7:0] OFS_RX_HOLD   = 8'h30;
    localparam logic [7:0] OFS_TX_HOLD   = 8'h34;
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_STOP_BIT   = 1;
    localparam int CTRL_ENABLE_BIT = 2;
    localparam int CTRL_DISABLE_BIT = 3;
    localparam int CTRL_SWRST_BIT  = 7;
    localparam int MODE_SIZE_LSB   = 8;
    localparam int MODE_READ_BIT   = 12;
    localparam int MODE_DADDR_LSB  = 16;
    localparam int CLK_HIGH_LSB    = 8;
    localparam int CLK_EXP_LSB     = 16;
    localparam int ST_COMPLETE_BIT = 0;
    localparam int ST_RX_READY_BIT    = 1;
    localparam int ST_TX_READY_BIT    = 2;
    localparam int ST_NOT_ACKNOWLEDGED_BIT     = 8;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0008;
    localparam logic [3:0]  CLK_EXTRA    = 4'h3;

    typedef struct packed {
        logic       read_direction;
        logic [1:0] internal_addr_size;
        logic [6:0] slave_device_address;
    } twm_mode_type;

    typedef struct packed {
        logic       scl_o;
        logic       scl_oe;
        logic       sda_o;
        logic       sda_oe;
    } twm_pins_type;
endpackage : twm_pkg

// ===== sim/tb_twm_master.sv
// self-checking bench for the two-wire master register block
`timescale 1ns/10ps
module tb_twm_master;
    import twm_pkg::*;
    logic         clk;
    logic         rst_n;
    logic [7:0]   avs_address;
    logic         avs_read;
    logic         avs_write;
    logic [31:0]  avs_writedata;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    twm_pins_type pins;
    logic         irq;
    logic         ack_en;
    logic [7:0]   rd_byte;
    logic         sda_pull;
    logic [7:0]   got_byte;
    logic         got_tgl;
    int           stops;
    wire          scl = !pins.scl_oe;
    wire          sda = !(pins.sda_oe || sda_pull);
    int           num_errors = 0;
    int           compares   = 0;
    logic [31:0]  exp_q[$];
    logic [31:0]  msk_q[$];
    logic [31:0]  wire_q[$];
    int           lows[$];
    int           highs[$];
    int           run     = 0;
    logic         prev_oe = 1'b0;
    logic [31:0]  v;
    logic [6:0]   dev;
    logic [23:0]  ia;
    logic [7:0]   ld;
    logic [7:0]   hd;
    logic [2:0]   ex;
    logic [7:0]   ro_ofs [9] = '{OFS_MODE, OFS_IADDR, OFS_CLKWAVE, OFS_STATUS, OFS_IRQ_MASK,
                                 OFS_RX_HOLD, OFS_TX_HOLD, 8'h08, 8'h3C};
    logic [7:0]   rw_ofs [5] = '{OFS_MODE, OFS_IADDR, OFS_CLKWAVE, OFS_TX_HOLD, 8'h08};
    logic [31:0]  rw_msk [5] = '{32'h007F_1300, 32'h00FF_FFFF, 32'h0007_FFFF, 32'h0000_00FF, '1};
    logic [7:0]   iq_ofs [4] = '{OFS_IRQ_EN, OFS_IRQ_EN, OFS_IRQ_DIS, OFS_IRQ_DIS};
    logic [31:0]  iq_dat [4] = '{32'h105, 32'h002, 32'h101, 32'h106};
    logic [31:0]  iq_exp [4] = '{32'h105, 32'h107, 32'h006, 32'h000};

    twm_master dut (
        .clk             (clk),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .scl_i           (scl),
        .sda_i           (sda),
        .pins            (pins),
        .irq             (irq)
    );
    twm_slave_model slv (
        .scl      (scl),
        .sda      (sda),
        .ack_en   (ack_en),
        .rd_byte  (rd_byte),
        .sda_pull (sda_pull),
        .got_byte (got_byte),
        .got_tgl  (got_tgl),
        .stops    (stops)
    );

    always #4 clk = !clk;

    task automatic stop_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
        compares++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("MISMATCH at %0t expected %h got %h", $time, e & m, g & m);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            num_errors++;
            stop_test();
        end
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic wait_stop();
        int s;
        s = stops;
        for (int i = 0; i < 20000 && stops == s; i++)
            @(posedge clk);
        if (stops == s) begin
            num_errors++;
            stop_test();
        end
        repeat (8) @(posedge clk);
    endtask : wait_stop

    function automatic logic [31:0] mode_word(input logic [6:0] d, input logic r,
                                              input logic [1:0] s);
        return {9'h0, d, 3'h0, r, 2'h0, s, 8'h0};
    endfunction : mode_word

    // read results against the oldest note
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            check(exp_q.pop_front(), avs_readdata, msk_q.pop_front());
    end
    // bytes seen by the slave against the oldest note
    always @(got_tgl) begin
        if (rst_n === 1'b1)
            check(wire_q.size() > 0 ? wire_q.pop_front() : 32'h100, {24'h0, got_byte}, 32'h1FF);
    end
    // length of each serial clock phase in clock cycles
    always @(posedge clk) begin
        if (pins.scl_oe === prev_oe) begin
            run++;
        end else begin
            if (prev_oe === 1'b1)
                lows.push_back(run);
            else
                highs.push_back(run);
            run = 1;
        end
        prev_oe = pins.scl_oe;
    end

    initial begin
        clk           = 1'b0;
        rst_n         = 1'b0;
        avs_address   = 8'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        ack_en        = 1'b1;
        rd_byte       = 8'h00;
        void'($urandom(26943));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd(ro_ofs[i], (ro_ofs[i] == OFS_STATUS) ? STATUS_RESET : 32'h0, '1);
        for (int i = 0; i < 15; i++) begin
            v = $urandom;
            wr(rw_ofs[i % 5], v);
            rd(rw_ofs[i % 5], (i % 5 == 4) ? 32'h0 : v, rw_msk[i % 5]);
        end
        wr(OFS_CTRL, 32'h0000_0080);
        rd(OFS_MODE, 32'h0, '1);
        for (int i = 0; i < 4; i++) begin
            wr(iq_ofs[i], iq_dat[i]);
            rd(OFS_IRQ_MASK, iq_exp[i], '1);
        end
        wr(OFS_CTRL, 32'h0000_0004);
        rd(OFS_STATUS, 32'h5, 32'h107);
        ld  = 8'($urandom_range(4, 1));
        hd  = 8'($urandom_range(4, 1));
        ex  = 3'($urandom_range(2, 0));
        dev = 7'($urandom);
        ia  = 24'($urandom);
        v   = 32'($urandom_range(255));
        wr(OFS_CLKWAVE, {13'h0, ex, hd, ld});
        wr(OFS_MODE, mode_word(dev, 1'b0, 2'b10));
        wr(OFS_IADDR, {8'h0, ia});
        wire_q.push_back({dev, 1'b0});
        wire_q.push_back(ia[15:8]);
        wire_q.push_back(ia[7:0]);
        wire_q.push_back(v);
        lows.delete();
        highs.delete();
        wr(OFS_TX_HOLD, v);
        @(posedge clk);
        rd(OFS_STATUS, 32'h0, 32'h5);
        wait_stop();
        rd(OFS_STATUS, 32'h5, 32'h107);
        check((32'(ld) << ex) + 3, lows[3], '1);
        check((32'(hd) << ex) + 3, highs[3], '1);
        rd_byte = 8'($urandom);
        wr(OFS_MODE, mode_word(dev, 1'b1, 2'b01));
        wire_q.push_back({dev, 1'b0});
        wire_q.push_back(ia[7:0]);
        wire_q.push_back({dev, 1'b1});
        wr(OFS_CTRL, 32'h0000_0003);
        wait_stop();
        rd(OFS_STATUS, 32'h7, 32'h107);
        rd(OFS_RX_HOLD, {24'h0, rd_byte}, '1);
        rd(OFS_STATUS, 32'h0, 32'h2);
        wr(OFS_IRQ_EN, 32'h100);
        ack_en = 1'b0;
        wr(OFS_MODE, mode_word(dev, 1'b0, 2'b00));
        wire_q.push_back({dev, 1'b0});
        wr(OFS_TX_HOLD, v);
        wait_stop();
        check(32'h1, {31'h0, irq}, 32'h1);
        rd(OFS_STATUS, 32'h105, 32'h107);
        rd(OFS_STATUS, 32'h0, 32'h100);
        @(posedge clk);
        check(32'h0, {31'h0, irq}, 32'h1);
        check(32'h0, 32'(wire_q.size()), '1);
        stop_test();
    end
endmodule : tb_twm_master

// ===== sim/twm_slave_model.sv
// behavioural two-wire slave that logs received bytes and answers reads
`timescale 1ns/10ps
module twm_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic [7:0] rd_byte,
    output logic            sda_pull,
    output logic [7:0]      got_byte,
    output logic            got_tgl,
    output int              stops
);
    logic [7:0] shreg = 8'h00;
    int         bitn  = 0;
    logic       first = 1'b0;
    logic       rd    = 1'b0;
    initial begin
        sda_pull = 1'b0;
        got_byte = 8'h00;
        got_tgl  = 1'b0;
        stops    = 0;
    end
    // start and stop conditions
    // let a clock edge of the same instant settle before judging the condition
    always @(negedge sda) begin
        #1;
        if (scl === 1'b1 && sda === 1'b0) begin
            bitn  = 0;
            first = 1'b1;
            rd    = 1'b0;
        end
    end
    always @(posedge sda) begin
        #1;
        if (scl === 1'b1 && sda === 1'b1)
            stops++;
    end
    // sample bits, msb first; a not_acknowledged from the master ends the read
    always @(posedge scl) begin
        if (bitn < 8) begin
            shreg = {shreg[6:0], sda};
            bitn++;
        end else begin
            if (sda === 1'b1)
                rd = 1'b0;
            bitn = 0;
        end
    end
    // drive acknowledge or read data while the clock is low
    always @(negedge scl) begin
        if (bitn == 8 && !rd) begin
            sda_pull = ack_en;
            if (first)
                rd = shreg[0] & ack_en;
            first    = 1'b0;
            got_byte = shreg;
            got_tgl  = !got_tgl;
        end else if (rd && bitn < 8) begin
            sda_pull = !rd_byte[7 - bitn];
        end else begin
            sda_pull = 1'b0;
        end
    end
endmodule : twm_slave_model
